// >>> rtl/cdp_defs.svh
// Constants of the 16-bit processor data path.
// Assumes inclusion by bare name from the data path sources.
`ifndef CDP_DEFS_SVH
`define CDP_DEFS_SVH

`define CDP_WORD_W 16
`define CDP_STATUS_W 8
`define CDP_REG_COUNT 16

`define CDP_ST_PRIO_HI 7
`define CDP_ST_PRIO_LO 5
`define CDP_ST_TRACE 4
`define CDP_ST_NEG 3
`define CDP_ST_ZERO 2
`define CDP_ST_OVFL 1
`define CDP_ST_CARRY 0

`define CDP_WORD_RESET 16'h0000
`define CDP_STATUS_RESET 8'h00

`define CDP_STATUS_ADDR 16'hFF00
`define CDP_SWITCH_ADDR 16'hFF02
`define CDP_STACK_LIMIT 16'h0100
`define CDP_RED_SPAN 16'h0020

`endif

// >>> rtl/cdp_pkg.sv
// Types shared by the data path modules.
// Assumes cdp_defs.svh sits beside it.
`default_nettype none
`include "cdp_defs.svh"

package cdp_pkg;

  typedef enum logic [1:0] {
    CDP_COUT_WORD,
    CDP_COUT_BYTE,
    CDP_COUT_MSB,
    CDP_COUT_STATUS
  } cdp_cout_sel_t;

  typedef enum logic [1:0] {
    CDP_CIN_ZERO,
    CDP_CIN_ONE,
    CDP_CIN_COND,
    CDP_CIN_STATUS
  } cdp_cin_sel_t;

  typedef struct packed {
    logic [15:0] result;
    logic carry_ext;
    logic [15:0] holding;
    logic [15:0] bus_addr;
    logic [7:0] status;
    logic status_addr_hit;
    logic switch_addr_hit;
    logic zero_low;
    logic zero_word;
    logic stack_limit_violation;
    logic red_zone;
  } cdp_state_t;

endpackage : cdp_pkg

`default_nettype wire

// >>> rtl/cdp_alu.sv
// 16-bit ALU: 16 logic and 16 arithmetic functions.
// Assumes operands and controls are steady within the clock cycle.
`timescale 1ns/10ps
`default_nettype none

module cdp_alu (
  // Operands
  input wire logic [15:0] alu_operand_a_i,
  input wire logic [15:0] alu_operand_b_i,
  // Controls
  input wire logic alu_logic_mode_i,
  input wire logic [3:0] alu_function_select_i,
  input wire logic carry_in_i,
  // Results
  output logic [15:0] alu_out_o,
  output logic word_carry_o,
  output logic byte_carry_o
);
  logic [15:0] x_term;
  logic [15:0] y_term;
  logic [8:0] low_sum;
  logic [8:0] high_sum;

  always_comb begin
    // Two-term form: arithmetic adds, logic takes the inverted xor
    x_term = alu_operand_a_i
      | (alu_operand_b_i & {16{alu_function_select_i[0]}})
      | (~alu_operand_b_i & {16{alu_function_select_i[1]}});
    y_term = (alu_operand_a_i & ~alu_operand_b_i
        & {16{alu_function_select_i[2]}})
      | (alu_operand_a_i & alu_operand_b_i
        & {16{alu_function_select_i[3]}});
    low_sum = {1'b0, x_term[7:0]} + {1'b0, y_term[7:0]}
      + {8'h00, carry_in_i};
    high_sum = {1'b0, x_term[15:8]} + {1'b0, y_term[15:8]}
      + {8'h00, low_sum[8]};
    if (alu_logic_mode_i) begin
      alu_out_o = ~(x_term ^ y_term);
    end else begin
      alu_out_o = {high_sum[7:0], low_sum[7:0]};
    end
    byte_carry_o = low_sum[8];
    word_carry_o = high_sum[8];
  end
  // No clock here: the add and carry checks sit beside the instance
endmodule : cdp_alu

`default_nettype wire

// >>> rtl/cdp_scratch_pad.sv
// Sixteen-word scratch pad, one address per cycle.
// Lets the sequencer ask read and write together; the write lands and the read drives zero.
`timescale 1ns/10ps
`default_nettype none
`include "cdp_defs.svh"

module cdp_scratch_pad #(
  parameter int DEPTH = `CDP_REG_COUNT
) (
  // Clock
  input wire logic core_clk_i,
  // Access
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [15:0] reg_wdata_i,
  // Wired-OR contribution
  output logic [15:0] reg_rdata_o
);
  logic [15:0] mem [DEPTH];

  // Four address bits reach exactly sixteen words
  if (DEPTH != 16) begin : g_bad_depth
    $error("scratch pad needs 16 words");
  end

  always_ff @(posedge core_clk_i) begin
    if (reg_write_i) begin
      mem[reg_addr_i] <= reg_wdata_i;
    end
  end

  // A write cycle drives zero so the wired-OR bus stays clean
  always_comb begin
    reg_rdata_o = (reg_read_i && !reg_write_i) ?
      mem[reg_addr_i] : 16'h0000;
  end

  no_rd_wr_a: assert property (@(posedge core_clk_i)
    reg_write_i |-> reg_rdata_o == 16'h0000)
    else $error("scratch pad drove read bus during write");
endmodule : cdp_scratch_pad

`default_nettype wire

// >>> rtl/cdp_data_path.sv
// 16-bit processor data path: ALU, muxes, result, holding,
// bus address and status registers, decoders, scratch pad.
// Assumes a microcode sequencer drives every select and load
// on core_clk_i; system bus timing sits outside.
`timescale 1ns/10ps
`default_nettype none
`include "cdp_defs.svh"

module cdp_data_path
  import cdp_pkg::*;
#(
  parameter logic [15:0] STATUS_ADDR = `CDP_STATUS_ADDR,
  parameter logic [15:0] SWITCH_ADDR = `CDP_SWITCH_ADDR,
  parameter logic [15:0] STACK_LIMIT = `CDP_STACK_LIMIT,
  parameter logic [15:0] RED_SPAN = `CDP_RED_SPAN
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // ALU control
  input wire logic alu_logic_mode_i,
  input wire logic [3:0] alu_function_select_i,
  input wire logic [1:0] carry_in_code_i,
  input wire logic carry_cond_i,
  input wire logic carry_cond_en_i,
  input wire logic [1:0] carry_out_select_i,
  // Multiplexer selects
  input wire logic bus_address_select_i,
  input wire logic result_input_select_hi_i,
  input wire logic result_input_select_lo_i,
  input wire logic operand_low_select_hi_i,
  input wire logic operand_low_select_lo_i,
  input wire logic operand_high_select_hi_i,
  input wire logic operand_high_select_lo_i,
  input wire logic [15:0] constant_generator_i,
  // Register loads
  input wire logic load_result_i,
  input wire logic load_bus_addr_i,
  input wire logic load_holding_i,
  input wire logic load_status_i,
  input wire logic load_cond_codes_i,
  input wire logic [3:0] cond_codes_i,
  input wire logic status_to_read_bus_i,
  input wire logic status_to_sys_bus_i,
  // Scratch pad
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  // Expansion buses
  input wire logic [15:0] ext_read_bus_i,
  output logic [15:0] result_input_bus_o,
  // System bus
  input wire logic [15:0] sys_bus_data_i,
  output logic [15:0] sys_bus_data_o,
  output logic sys_bus_data_oe_o,
  output logic [15:0] sys_bus_addr_o,
  // Status and decode
  output logic [7:0] processor_status_o,
  output logic [15:0] result_o,
  output logic carry_ext_o,
  output logic zero_low_o,
  output logic zero_word_o,
  output logic status_addr_hit_o,
  output logic switch_addr_hit_o,
  output logic stack_limit_violation_o,
  output logic stack_red_zone_o
);
  cdp_state_t s;
  cdp_state_t next_s;
  logic [15:0] reg_rdata;
  logic [15:0] read_bus;
  logic [15:0] alu_operand_b;
  logic [15:0] alu_out;
  logic [15:0] result_input;
  logic [15:0] next_addr_mux;
  logic word_carry;
  logic byte_carry;
  logic carry_in;
  logic carry_out_sel;
  logic status_on_sys;
  logic [7:0] operand_low;
  logic [7:0] operand_high;
  logic [1:0] low_sel;
  logic [1:0] high_sel;
  logic [1:0] rin_sel;

  if (RED_SPAN > STACK_LIMIT) begin : g_bad_span
    $error("red span exceeds stack limit");
  end

  assign low_sel = {operand_low_select_hi_i, operand_low_select_lo_i};
  assign high_sel = {operand_high_select_hi_i, operand_high_select_lo_i};
  assign rin_sel = {result_input_select_hi_i, result_input_select_lo_i};

  // Status is driven to the system bus only when addressed there
  assign status_on_sys = status_to_sys_bus_i && s.status_addr_hit;

  cdp_scratch_pad #(
    .DEPTH(`CDP_REG_COUNT)
  ) u_scratch_pad (
    .core_clk_i(core_clk_i),
    .reg_addr_i(reg_addr_i),
    .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i),
    .reg_wdata_i(result_input),
    .reg_rdata_o(reg_rdata)
  );

  always_comb begin
    // Wired-OR of every source hanging on the read bus
    read_bus = reg_rdata | ext_read_bus_i;
    if (status_to_read_bus_i && !status_on_sys) begin
      read_bus = read_bus | {8'h00, s.status};
    end
  end

  always_comb begin
    case (carry_in_code_i)
      CDP_CIN_ZERO: carry_in = 1'b0;
      CDP_CIN_ONE: carry_in = 1'b1;
      CDP_CIN_COND: carry_in = carry_cond_en_i && carry_cond_i;
      CDP_CIN_STATUS: carry_in = s.status[`CDP_ST_CARRY];
      default: carry_in = 1'b0;
    endcase
  end

  always_comb begin
    case (low_sel)
      2'b00: operand_low = s.holding[7:0];
      2'b01: operand_low = s.holding[7:0];
      2'b10: operand_low = s.holding[15:8];
      2'b11: operand_low = constant_generator_i[7:0];
      default: operand_low = s.holding[7:0];
    endcase
    case (high_sel)
      2'b00: operand_high = s.holding[15:8];
      2'b01: operand_high = {8{s.holding[7]}};
      2'b10: operand_high = s.holding[7:0];
      2'b11: operand_high = constant_generator_i[15:8];
      default: operand_high = s.holding[15:8];
    endcase
    // Pairs of codes give straight, extend, swap, dup, constant
    alu_operand_b = {operand_high, operand_low};
  end

  cdp_alu u_alu (
    .alu_operand_a_i(read_bus),
    .alu_operand_b_i(alu_operand_b),
    .alu_logic_mode_i(alu_logic_mode_i),
    .alu_function_select_i(alu_function_select_i),
    .carry_in_i(carry_in),
    .alu_out_o(alu_out),
    .word_carry_o(word_carry),
    .byte_carry_o(byte_carry)
  );

  always_comb begin
    case (carry_out_select_i)
      CDP_COUT_WORD: carry_out_sel = word_carry;
      CDP_COUT_BYTE: carry_out_sel = byte_carry;
      CDP_COUT_MSB: carry_out_sel = alu_out[15];
      CDP_COUT_STATUS: carry_out_sel = s.status[`CDP_ST_CARRY];
      default: carry_out_sel = word_carry;
    endcase
  end

  always_comb begin
    case (rin_sel)
      2'b00: result_input = read_bus;
      2'b01: result_input = sys_bus_data_i;
      2'b10: result_input = s.result;
      2'b11: result_input = {s.carry_ext, s.result[15:1]};
      default: result_input = read_bus;
    endcase
    next_addr_mux = bus_address_select_i ? alu_out : read_bus;
  end

  // Outgoing bus for expansion units; combinational by nature
  assign result_input_bus_o = result_input;

  always_comb begin
    next_s = s;
    if (load_result_i) begin
      next_s.result = alu_out;
      next_s.carry_ext = carry_out_sel;
    end
    if (load_bus_addr_i) begin
      next_s.bus_addr = next_addr_mux;
    end
    if (load_holding_i) begin
      next_s.holding = result_input;
    end
    if (load_status_i) begin
      next_s.status = result_input[7:0];
    end
    if (load_cond_codes_i) begin
      next_s.status[`CDP_ST_NEG:`CDP_ST_CARRY] = cond_codes_i;
    end
    // Decoders sit on the register contents, held as flops
    next_s.zero_low = next_s.result[7:0] == 8'h00;
    next_s.zero_word = next_s.result == 16'h0000;
    next_s.status_addr_hit = next_s.bus_addr == STATUS_ADDR;
    next_s.switch_addr_hit = next_s.bus_addr == SWITCH_ADDR;
    next_s.stack_limit_violation = next_s.bus_addr < STACK_LIMIT;
    next_s.red_zone = next_s.bus_addr < (STACK_LIMIT - RED_SPAN);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.status <= `CDP_STATUS_RESET;
      s.zero_low <= 1'b1;
      s.zero_word <= 1'b1;
      s.stack_limit_violation <= 1'b1;
      s.red_zone <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Output register for system bus drive
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sys_bus_data_o <= `CDP_WORD_RESET;
      sys_bus_data_oe_o <= 1'b0;
    end else begin
      sys_bus_data_o <= status_on_sys ? {8'h00, s.status} : s.result;
      sys_bus_data_oe_o <= status_on_sys;
    end
  end

  assign sys_bus_addr_o = s.bus_addr;
  assign processor_status_o = s.status;
  assign result_o = s.result;
  assign carry_ext_o = s.carry_ext;
  assign zero_low_o = s.zero_low;
  assign zero_word_o = s.zero_word;
  assign status_addr_hit_o = s.status_addr_hit;
  assign switch_addr_hit_o = s.switch_addr_hit;
  assign stack_limit_violation_o = s.stack_limit_violation;
  assign stack_red_zone_o = s.red_zone;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  result_hold_a: assert property (
    !load_result_i |=> $stable(s.result) && $stable(s.carry_ext))
    else $error("result changed without load");

  carry_ext_a: assert property (
    load_result_i && carry_out_select_i == 2'b01
      |=> s.carry_ext == $past(byte_carry))
    else $error("carry extension missed byte carry");

  addr_mux_a: assert property (
    load_bus_addr_i && !bus_address_select_i
      |=> s.bus_addr == $past(read_bus))
    else $error("address did not take read bus");

  shift_right_a: assert property (
    load_holding_i && rin_sel == 2'b11
      |=> s.holding == {$past(s.carry_ext), $past(s.result[15:1])})
    else $error("shift right path wrong");

  sign_extend_a: assert property (
    high_sel == 2'b01 |-> alu_operand_b[15:8] == {8{s.holding[7]}})
    else $error("sign extension wrong");

  zero_word_a: assert property (
    zero_word_o == (result_o == 16'h0000))
    else $error("word zero flag wrong");

  status_hit_a: assert property (
    status_addr_hit_o == (sys_bus_addr_o == STATUS_ADDR))
    else $error("status address hit wrong");

  red_implies_a: assert property (
    stack_red_zone_o |-> stack_limit_violation_o)
    else $error("red zone without violation");

  cc_load_a: assert property (
    load_cond_codes_i |=> s.status[3:0] == $past(cond_codes_i))
    else $error("condition codes not loaded");

  status_drive_a: assert property (
    status_on_sys |=> sys_bus_data_oe_o
      && sys_bus_data_o == {8'h00, $past(s.status)})
    else $error("status not driven on system bus");

  cin_cond_a: assert property (
    carry_in_code_i == 2'b10 && !carry_cond_en_i |-> !carry_in)
    else $error("carry-in taken without enable");

  // Plain sum, independent of the two-term form inside the ALU
  alu_add_a: assert property (
    !alu_logic_mode_i && alu_function_select_i == 4'h9
      |-> alu_out == read_bus + alu_operand_b + 16'(carry_in))
    else $error("ALU add function wrong");

  msb_carry_a: assert property (
    load_result_i && carry_out_select_i == 2'b10
      |=> s.carry_ext == $past(alu_out[15]))
    else $error("carry extension missed ALU msb");

  zero_low_a: assert property (
    zero_low_o == (result_o[7:0] == 8'h00))
    else $error("low byte zero flag wrong");

  switch_hit_a: assert property (
    switch_addr_hit_o == (sys_bus_addr_o == SWITCH_ADDR))
    else $error("switch address hit wrong");

  stack_limit_a: assert property (
    stack_limit_violation_o == (sys_bus_addr_o < STACK_LIMIT))
    else $error("stack limit flag wrong");

  swap_cov: cover property (low_sel == 2'b10 && high_sel == 2'b10);
  rotate_cov: cover property (load_holding_i && rin_sel == 2'b11);
  red_cov: cover property (stack_red_zone_o);
  status_bus_cov: cover property (sys_bus_data_oe_o);
endmodule : cdp_data_path

`default_nettype wire

// >>> tb/cdp_bus_model.sv
// Far-side model: system bus data source and expansion read bus.
// Assumes the bench sets its requests at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none

module cdp_bus_model (
  // Clock
  input wire logic core_clk_i,
  // Requests from the bench
  input wire logic sys_en_i,
  input wire logic [15:0] sys_val_i,
  input wire logic ext_en_i,
  input wire logic [15:0] ext_val_i,
  // Lines into the data path
  output logic [15:0] sys_bus_data_o,
  output logic [15:0] ext_read_bus_o
);
  logic [15:0] last = 16'hA5A5;

  // Released data lines flip every cycle, starting from the inverse of the last driven value
  always @(posedge core_clk_i) begin
    last <= sys_en_i ? sys_val_i : ~last;
  end
  assign sys_bus_data_o = sys_en_i ? sys_val_i : ~last;
  // Idle wired-OR contribution is zero
  assign ext_read_bus_o = ext_en_i ? ext_val_i : 16'h0000;
endmodule : cdp_bus_model

`default_nettype wire

// >>> tb/cdp_data_path_test.sv
// Bench for the 16-bit data path: micro-op tasks and checked sequences.
// Assumes the bus model feeds system bus data and the read bus.
`timescale 1ns/10ps
`default_nettype none

module cdp_data_path_test;
  logic core_clk_i, rst_n_i, alu_logic_mode_i, carry_cond_i, carry_cond_en_i;
  logic bus_address_select_i, result_input_select_hi_i;
  logic result_input_select_lo_i, operand_low_select_hi_i;
  logic operand_low_select_lo_i, operand_high_select_hi_i;
  logic operand_high_select_lo_i, load_result_i, load_bus_addr_i;
  logic load_holding_i, load_status_i, load_cond_codes_i, sys_en, ext_en;
  logic status_to_read_bus_i, status_to_sys_bus_i, reg_write_i, reg_read_i;
  logic sys_bus_data_oe_o, carry_ext_o, zero_low_o, zero_word_o;
  logic status_addr_hit_o, switch_addr_hit_o, stack_limit_violation_o;
  logic stack_red_zone_o;
  logic [1:0] carry_in_code_i, carry_out_select_i;
  logic [3:0] alu_function_select_i, cond_codes_i, reg_addr_i;
  logic [7:0] processor_status_o;
  logic [15:0] constant_generator_i, ext_read_bus_i, result_input_bus_o;
  logic [15:0] sys_bus_data_i, sys_bus_data_o, sys_bus_addr_o, result_o;
  logic [15:0] sys_val, ext_val;
  logic [16:0] e;
  logic [15:0] av [7] = '{16'hFF00, 16'hFF02, 16'h00F0, 16'h00F0, 16'h00D0,
    16'h00CF, 16'hFEF0};
  logic [15:0] ae [7] = '{16'hFF00, 16'hFF02, 16'h00F0, 16'h0100, 16'h00E0,
    16'h00DF, 16'hFF00};
  logic [3:0] fe [7] = '{4'h8, 4'h4, 4'h2, 4'h0, 4'h2, 4'h3, 4'h8};
  int error_cnt = 0;
  int check_count = 0;

  cdp_data_path u_dut (
    .core_clk_i, .rst_n_i, .alu_logic_mode_i, .alu_function_select_i,
    .carry_in_code_i, .carry_cond_i, .carry_cond_en_i, .carry_out_select_i,
    .bus_address_select_i, .result_input_select_hi_i,
    .result_input_select_lo_i, .operand_low_select_hi_i,
    .operand_low_select_lo_i, .operand_high_select_hi_i,
    .operand_high_select_lo_i, .constant_generator_i, .load_result_i,
    .load_bus_addr_i, .load_holding_i, .load_status_i, .load_cond_codes_i,
    .cond_codes_i, .status_to_read_bus_i, .status_to_sys_bus_i, .reg_addr_i,
    .reg_write_i, .reg_read_i, .ext_read_bus_i, .result_input_bus_o,
    .sys_bus_data_i, .sys_bus_data_o, .sys_bus_data_oe_o, .sys_bus_addr_o,
    .processor_status_o, .result_o, .carry_ext_o, .zero_low_o, .zero_word_o,
    .status_addr_hit_o, .switch_addr_hit_o, .stack_limit_violation_o,
    .stack_red_zone_o
  );

  cdp_bus_model u_bus (
    .core_clk_i, .sys_en_i(sys_en), .sys_val_i(sys_val), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .sys_bus_data_o(sys_bus_data_i),
    .ext_read_bus_o(ext_read_bus_i)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // Expected ALU word with carry, from the function equations
  function automatic logic [16:0] fn(input logic [15:0] a, input logic m,
      input logic [3:0] s, input logic ci);
    logic [15:0] x;
    logic [15:0] y;
    x = a | (16'h3C5A & {16{s[0]}}) | (~16'h3C5A & {16{s[1]}});
    y = (a & ~16'h3C5A & {16{s[2]}}) | (a & 16'h3C5A & {16{s[3]}});
    fn = m ? {1'b0, ~(x ^ y)} : {1'b0, x} + {1'b0, y} + 17'(ci);
  endfunction : fn

  function automatic logic [15:0] bmux(input logic [3:0] j);
    case (j[3:2])
      2'h0: bmux[15:8] = 8'h3C;
      2'h1: bmux[15:8] = 8'hFF;
      2'h2: bmux[15:8] = 8'h95;
      default: bmux[15:8] = 8'hC3;
    endcase
    case (j[1:0])
      2'h2: bmux[7:0] = 8'h3C;
      2'h3: bmux[7:0] = 8'h7E;
      default: bmux[7:0] = 8'h95;
    endcase
  endfunction : bmux

  function automatic logic [15:0] pat(input logic [3:0] k);
    pat = 16'h0F0F ^ {k, k, k, k};
  endfunction : pat

  task automatic clr;
    {alu_logic_mode_i, carry_cond_i, carry_cond_en_i, bus_address_select_i,
     result_input_select_hi_i, result_input_select_lo_i,
     operand_low_select_hi_i, operand_low_select_lo_i,
     operand_high_select_hi_i, operand_high_select_lo_i, load_result_i,
     load_bus_addr_i, load_holding_i, load_status_i, load_cond_codes_i,
     status_to_read_bus_i, status_to_sys_bus_i, reg_write_i, reg_read_i,
     sys_en, ext_en, carry_in_code_i, carry_out_select_i,
     alu_function_select_i, cond_codes_i, reg_addr_i} = '0;
  endtask : clr

  task automatic tick;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    clr();
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rsel(input logic [1:0] v);
    {result_input_select_hi_i, result_input_select_lo_i} = v;
  endtask : rsel

  task automatic sys(input logic [15:0] v);
    rsel(2'h1);
    sys_val = v;
    sys_en = 1'b1;
  endtask : sys

  task automatic hold(input logic [15:0] v);
    sys(v);
    load_holding_i = 1'b1;
    tick();
  endtask : hold

  task automatic alu(input logic [15:0] a, input logic m,
      input logic [3:0] s, input logic [1:0] ci);
    ext_val = a;
    ext_en = 1'b1;
    alu_logic_mode_i = m;
    alu_function_select_i = s;
    carry_in_code_i = ci;
    load_result_i = 1'b1;
  endtask : alu

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (check_count > 0 && error_cnt == 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // About 150 cycles of work; 4000 leaves ample margin
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

  initial begin
    rst_n_i = 1'b0;
    constant_generator_i = 16'hC37E;
    sys_val = 16'h0000;
    ext_val = 16'h0000;
    clr();
    repeat (6) @(negedge core_clk_i);
    chk(result_o, 16'h0000);
    chk(16'({sys_bus_data_oe_o, processor_status_o}), 16'h0000);
    chk(16'({zero_word_o, stack_limit_violation_o}), 16'h0003);
    rst_n_i = 1'b1;
    hold(16'h3C5A);
    for (int i = 0; i < 64; i++) begin
      alu(16'h96F0, i[5], i[3:0], {1'b0, i[4]});
      tick();
      e = fn(16'h96F0, i[5], i[3:0], i[4]);
      chk(result_o, e[15:0]);
      chk(16'({zero_low_o, zero_word_o}), 16'({e[7:0] == 8'h00,
        e[15:0] == 16'h0000}));
      chk(16'(carry_ext_o | i[5]), 16'(e[16] | i[5]));
    end
    hold(16'h3C95);
    for (int j = 0; j < 16; j++) begin
      {operand_high_select_hi_i, operand_high_select_lo_i} = j[3:2];
      {operand_low_select_hi_i, operand_low_select_lo_i} = j[1:0];
      alu(16'h0000, 1'b1, 4'hA, 2'h0);
      tick();
      chk(result_o, bmux(j[3:0]));
    end
    for (int i = 0; i < 3; i++) begin
      sys(16'h00FF ^ {8'h00, 8'h1A * i[7:0]});
      load_status_i = (i < 2);
      load_cond_codes_i = (i > 0);
      cond_codes_i = (i == 1) ? 4'hA : 4'h1;
      tick();
      chk(16'(processor_status_o), i == 0 ? 16'h00FF : i == 1 ? 16'h00EA
        : 16'h00E1);
    end
    hold(16'h0001);
    for (int i = 0; i < 8; i++) begin
      carry_out_select_i = i[1:0];
      alu(i[2] ? 16'h80FF : 16'hFFFF, 1'b0, 4'h9, 2'h0);
      tick();
      chk(16'(carry_ext_o), {15'h0000, i[0] | (i[1] ^ ~i[2])});
    end
    chk(result_o, 16'h8100);
    rsel(2'h2);
    #1 chk(result_input_bus_o, 16'h8100);
    rsel(2'h3);
    #1 chk(result_input_bus_o, 16'hC080);
    sys(16'h5AA5);
    #1 chk(result_input_bus_o, 16'h5AA5);
    for (int i = 0; i < 5; i++) begin
      carry_cond_i = 1'b1;
      carry_cond_en_i = (i != 4);
      alu(16'h0000, 1'b0, 4'h9, i == 4 ? 2'h2 : i[1:0]);
      tick();
      chk(result_o, (i == 0 || i == 4) ? 16'h0001 : 16'h0002);
    end
    hold(16'h0010);
    for (int i = 0; i < 7; i++) begin
      alu(av[i], 1'b0, 4'h9, 2'h0);
      bus_address_select_i = (i > 2);
      load_bus_addr_i = 1'b1;
      tick();
      chk(sys_bus_addr_o, ae[i]);
      chk(16'({status_addr_hit_o, switch_addr_hit_o, stack_limit_violation_o,
        stack_red_zone_o}), 16'(fe[i]));
    end
    alu(16'hFF02, 1'b0, 4'h9, 2'h0);
    tick();
    chk(sys_bus_addr_o, 16'hFF00);
    chk(16'(status_addr_hit_o), 16'h0001);
    status_to_sys_bus_i = 1'b1;
    status_to_read_bus_i = 1'b1;
    #1 chk(result_input_bus_o, 16'h0000);
    tick();
    chk(16'(sys_bus_data_oe_o), 16'h0001);
    chk(sys_bus_data_o, 16'h00E1);
    ext_val = 16'hFF02;
    ext_en = 1'b1;
    load_bus_addr_i = 1'b1;
    tick();
    chk(16'(sys_bus_data_oe_o), 16'h0000);
    status_to_sys_bus_i = 1'b1;
    status_to_read_bus_i = 1'b1;
    #1 chk(result_input_bus_o, 16'h00E1);
    tick();
    chk(16'(sys_bus_data_oe_o), 16'h0000);
    for (int k = 0; k < 16; k++) begin
      sys(pat(k[3:0]));
      reg_addr_i = k[3:0];
      reg_write_i = 1'b1;
      tick();
    end
    for (int k = 0; k < 16; k++) begin
      reg_addr_i = k[3:0];
      reg_read_i = 1'b1;
      #1 chk(result_input_bus_o, pat(k[3:0]));
      tick();
    end
    reg_addr_i = 4'h3;
    reg_read_i = 1'b1;
    reg_write_i = 1'b1;
    #1 chk(result_input_bus_o, 16'h0000);
    tick();
    // Result FF12 with clear extension shifts right into holding
    rsel(2'h3);
    load_holding_i = 1'b1;
    tick();
    alu(16'h0000, 1'b1, 4'hA, 2'h0);
    tick();
    chk(result_o, 16'h7F89);
    conclude();
  end
endmodule : cdp_data_path_test

`default_nettype wire
